// ==== design/uar_params.svh ====
`ifndef UAR_PARAMS_SVH
`define UAR_PARAMS_SVH

// register byte offsets on the apb slave
`define UAR_OFF_CTRL     12'h000
`define UAR_OFF_BAUD     12'h004
`define UAR_OFF_STATUS   12'h008
`define UAR_OFF_RXBUF    12'h00c

// control field positions
`define UAR_CTRL_ON        0
`define UAR_CTRL_RX_ENABLE 1
`define UAR_CTRL_TX_ENABLE 2
`define UAR_CTRL_SPEED     3
`define UAR_CTRL_RXINV     4
`define UAR_CTRL_FE_ENABLE 5
`define UAR_CTRL_PE_ENABLE 6
`define UAR_CTRL_MODE_LO   8

// reset values
`define UAR_CTRL_RESET   32'h0000_0000
`define UAR_BAUD_RESET   16'h0000

// mode encodings
`define UAR_MODE_8N      4'h0
`define UAR_MODE_7N      4'h1
`define UAR_MODE_ODD     4'h2
`define UAR_MODE_EVEN    4'h3

// oversampling figures
`define UAR_TICKS_NORMAL 5'h10
`define UAR_TICKS_HIGH   5'h04
`define UAR_SAMPLE_A     5'h07
`define UAR_SAMPLE_B     5'h08
`define UAR_SAMPLE_C     5'h09

`endif

// ==== design/uar_pkg.sv ====
package uar_pkg;

    typedef enum logic [2:0] {
        UAR_IDLE  = 3'b000,
        UAR_EDGE  = 3'b001,
        UAR_START = 3'b010,
        UAR_DATA  = 3'b011,
        UAR_PAR   = 3'b100,
        UAR_STOP  = 3'b101
    } uar_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       ferr;
        logic       perr;
    } uar_entry_t;

endpackage : uar_pkg

// ==== design/uar_receiver.sv ====
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "uar_params.svh"
`default_nettype none

module uar_receiver #(
    parameter int BAUD_W = 16
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_pin,
    output logic             rx_ready_flag,
    output logic             summary_error_event,
    output logic             tx_buffer_free_flag
);

    typedef struct packed {
        logic [31:0]             ctrl;
        logic [BAUD_W-1:0]       baud_divisor;
        logic [BAUD_W-1:0]       div_cnt;
        uar_pkg::uar_state_t     state;
        logic [4:0]              tick_cnt;
        logic [2:0]              samples;
        logic [2:0]              bit_cnt;
        logic [7:0]              rx_shift_register;
        logic                    par_bit;
        uar_pkg::uar_entry_t [1:0] fifo;
        logic [1:0]              count;
        logic                    rx_overflow_flag;
        logic                    line_prev;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic                    rx_ready;
        logic                    err_evt;
        logic                    tx_free;
    } uar_st_t;

    uar_st_t st_reg;
    uar_st_t st_next;

    // majority of three samples
    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : maj3

    // recovered bit: single sample at high speed, majority of three otherwise
    function automatic logic pick_bit(input logic [2:0] s, input logic hs);
        pick_bit = hs ? s[0] : maj3(s);
    endfunction : pick_bit

    // modes that carry a ninth parity bit
    function automatic logic is_par_mode(input logic [3:0] m);
        is_par_mode = (m == `UAR_MODE_ODD) || (m == `UAR_MODE_EVEN);
    endfunction : is_par_mode

    // index of the final data bit: seven or eight bits per character
    function automatic logic [2:0] last_data_bit(input logic [3:0] m);
        last_data_bit = (m == `UAR_MODE_7N) ? 3'h6 : 3'h7;
    endfunction : last_data_bit

    // status word: count, overflow, event, tx free, top flags, ready
    function automatic logic [31:0] status_word(input logic [1:0] cnt,
                                                 input logic       ovf,
                                                 input logic       evt,
                                                 input logic       txf,
                                                 input logic       pe,
                                                 input logic       fe,
                                                 input logic       rdy);
        status_word = {24'h0, cnt, ovf, evt, txf, pe, fe, rdy};
    endfunction : status_word

    // control fields
    logic       port_on;
    logic       rx_on;
    logic       hi_speed;
    logic [3:0] mode;

    // receive path
    logic       line;
    logic       start_edge;
    logic       tick;
    logic [4:0] bit_ticks;
    logic       last_tick;
    logic [7:0] char_data;
    logic       par_calc;

    // fifo, flags and bus
    logic       access;
    uar_pkg::uar_entry_t new_ent;
    logic       push;
    logic       pop;
    logic       top_ferr;
    logic       top_perr;
    logic       fe_hold;
    logic       pe_hold;
    logic       supp;

    // control fields
    assign port_on   = st_reg.ctrl[`UAR_CTRL_ON];
    assign rx_on     = st_reg.ctrl[`UAR_CTRL_RX_ENABLE] & port_on;
    assign hi_speed  = st_reg.ctrl[`UAR_CTRL_SPEED];
    assign mode      = st_reg.ctrl[`UAR_CTRL_MODE_LO +: 4];

    // polarity-corrected line and its falling edge; history resets to idle
    assign line       = rx_pin ^ st_reg.ctrl[`UAR_CTRL_RXINV];
    assign start_edge = st_reg.line_prev & ~line;

    // baud tick and bit length in ticks
    assign tick      = (st_reg.div_cnt == st_reg.baud_divisor);
    assign bit_ticks = hi_speed ? `UAR_TICKS_HIGH : `UAR_TICKS_NORMAL;
    assign last_tick = (st_reg.tick_cnt == bit_ticks - 5'h01);

    // character as the host sees it; 7-bit mode right-aligns it
    assign char_data = (mode == `UAR_MODE_7N) ? {1'b0, st_reg.rx_shift_register[7:1]}
                                              : st_reg.rx_shift_register;
    // parity check over data and ninth bit; one means a parity error
    assign par_calc  = ^st_reg.rx_shift_register ^ st_reg.par_bit ^ (mode == `UAR_MODE_ODD);

    // bus access phase and flags of the top entry, zero while the fifo is empty
    assign access    = psel & penable;
    assign top_ferr  = (st_reg.count != 2'd0) & st_reg.fifo[0].ferr;
    assign top_perr  = (st_reg.count != 2'd0) & st_reg.fifo[0].perr;

    // next state: defaults hold every field, strobes low
    always_comb begin
        logic bitval;
        bitval = 1'b0;
        st_next = st_reg;
        push = 1'b0;
        new_ent = '0;
        pop = 1'b0;

        // baud tick divider and line history
        st_next.div_cnt = tick ? '0 : st_reg.div_cnt + 1'b1;
        st_next.line_prev = line;

        // data recovery: one sample in high speed, majority of 7/8/9 in normal
        bitval = pick_bit(st_reg.samples, hi_speed);
        if (tick && st_reg.state != uar_pkg::UAR_IDLE) begin
            st_next.tick_cnt = last_tick ? 5'h00 : st_reg.tick_cnt + 5'h01;
            if (hi_speed) begin
                if (st_reg.tick_cnt == 5'h01)
                    st_next.samples = {2'b00, line};
            end else begin
                unique case (st_reg.tick_cnt)
                    `UAR_SAMPLE_A: st_next.samples[0] = line;
                    `UAR_SAMPLE_B: st_next.samples[1] = line;
                    `UAR_SAMPLE_C: st_next.samples[2] = line;
                    default:       ;
                endcase
            end
        end

        // receive state machine
        unique case (st_reg.state)
            uar_pkg::UAR_IDLE: begin
                // counter held at zero while waiting
                st_next.tick_cnt = 5'h00;
                // falling edge of start bit
                if (rx_on && start_edge) begin
                    st_next.state = hi_speed ? uar_pkg::UAR_START : uar_pkg::UAR_EDGE;
                    st_next.div_cnt = '0;
                    st_next.samples = 3'b111;
                end
            end
            uar_pkg::UAR_EDGE: begin
                // leading edge check at ticks one and two
                if (tick && st_reg.tick_cnt == 5'h01)
                    st_next.samples[0] = line;
                if (tick && st_reg.tick_cnt == 5'h02) begin
                    if (st_reg.samples[0] && line)
                        st_next.state = uar_pkg::UAR_IDLE;
                    else
                        st_next.state = uar_pkg::UAR_START;
                end
            end
            uar_pkg::UAR_START: begin
                // mid-bit start check, recovered bit low to go on
                if (tick && last_tick) begin
                    st_next.bit_cnt = 3'h0;
                    if (bitval)
                        st_next.state = uar_pkg::UAR_IDLE;
                    else
                        st_next.state = uar_pkg::UAR_DATA;
                end
            end
            uar_pkg::UAR_DATA: begin
                if (tick && last_tick) begin
                    // lsb first into the shift register
                    st_next.rx_shift_register = {bitval,
                                                 st_reg.rx_shift_register[7:1]};
                    st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                    if (st_reg.bit_cnt == last_data_bit(mode))
                        st_next.state = is_par_mode(mode)
                                        ? uar_pkg::UAR_PAR : uar_pkg::UAR_STOP;
                end
            end
            uar_pkg::UAR_PAR: begin
                // ninth bit carries the parity
                if (tick && last_tick) begin
                    st_next.par_bit = bitval;
                    st_next.state = uar_pkg::UAR_STOP;
                end
            end
            uar_pkg::UAR_STOP: begin
                // stop sample, then hand the character to the fifo
                if (tick && last_tick) begin
                    st_next.state = uar_pkg::UAR_IDLE;
                    push = 1'b1;
                    new_ent.data = char_data;
                    new_ent.ferr = ~bitval;
                    new_ent.perr = is_par_mode(mode) & par_calc;
                end
            end
            default: st_next.state = uar_pkg::UAR_IDLE;
        endcase

        // receiver off or port off forces start detection
        if (!rx_on)
            st_next.state = uar_pkg::UAR_IDLE;

        // apb slave: one wait state, pready rises the cycle after the access
        // is taken and stands for one cycle
        st_next.pready = access & ~st_reg.pready;
        st_next.pslverr = 1'b0;
        st_next.prdata = 32'h0000_0000;
        if (access && !st_reg.pready) begin
            if (pwrite) begin
                unique case (paddr)
                    `UAR_OFF_CTRL:   st_next.ctrl = pwdata;
                    `UAR_OFF_BAUD:   st_next.baud_divisor = pwdata[BAUD_W-1:0];
                    `UAR_OFF_STATUS: begin
                        // writing one to the overflow bit clears it
                        if (pwdata[5])
                            st_next.rx_overflow_flag = 1'b0;
                    end
                    `UAR_OFF_RXBUF:  ;
                    default:         st_next.pslverr = 1'b1;
                endcase
            end else begin
                unique case (paddr)
                    `UAR_OFF_CTRL:   st_next.prdata = st_reg.ctrl;
                    `UAR_OFF_BAUD:   st_next.prdata = 32'(st_reg.baud_divisor);
                    `UAR_OFF_STATUS: st_next.prdata = status_word(st_reg.count,
                                         st_reg.rx_overflow_flag, st_reg.err_evt,
                                         st_reg.tx_free, top_perr, top_ferr,
                                         st_reg.rx_ready);
                    `UAR_OFF_RXBUF: begin
                        st_next.prdata = {24'h0, st_reg.fifo[0].data};
                        pop = (st_reg.count != 2'd0);
                    end
                    default:         st_next.pslverr = 1'b1;
                endcase
            end
        end

        // fifo: pop shifts entry one to top, push fills next free slot
        if (pop) begin
            st_next.fifo[0] = st_reg.fifo[1];
            st_next.count = st_reg.count - 2'd1;
        end
        if (push) begin
            if (st_reg.count == 2'd2 && !pop) begin
                st_next.rx_overflow_flag = 1'b1;
            end else begin
                st_next.fifo[st_next.count[0]] = new_ent;
                st_next.count = st_next.count + 2'd1;
            end
        end
        // port off empties the fifo and so clears its ready and error flags; the overflow flag is kept
        if (!port_on) begin
            st_next.count = 2'd0;
            st_next.fifo = '0;
        end

        // top-entry flags, suppression and summary event
        fe_hold = st_next.fifo[0].ferr && st_next.ctrl[`UAR_CTRL_FE_ENABLE];
        pe_hold = st_next.fifo[0].perr && st_next.ctrl[`UAR_CTRL_PE_ENABLE];
        supp    = (st_next.count != 2'd0) && (fe_hold || pe_hold);
        st_next.rx_ready = (st_next.count != 2'd0) && !supp;
        st_next.err_evt = supp;
        // transmit buffer reported free while the port and transmitter are on
        st_next.tx_free = st_next.ctrl[`UAR_CTRL_TX_ENABLE] && st_next.ctrl[`UAR_CTRL_ON];
    end

    // state register; line history resets to idle so no false start edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.line_prev <= 1'b1;
            st_reg.ctrl <= `UAR_CTRL_RESET;
            st_reg.baud_divisor <= `UAR_BAUD_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata              = st_reg.prdata;
    assign pready              = st_reg.pready;
    assign pslverr             = st_reg.pslverr;
    assign rx_ready_flag       = st_reg.rx_ready;
    assign summary_error_event = st_reg.err_evt;
    assign tx_buffer_free_flag = st_reg.tx_free;

endmodule : uar_receiver
`default_nettype wire

// ==== bench/uar_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module uar_chk (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_pin,
    input wire logic        rx_ready_flag,
    input wire logic        summary_error_event,
    input wire logic        tx_buffer_free_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // bus answer timing
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready long");
    pready_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    pready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
    slverr_qual_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    // tx flag changes and rx ready drops only through host access
    txfree_cause_a: assert property ($changed(tx_buffer_free_flag) |->
        $past(psel, 1) || $past(psel, 2) || $past(psel, 3)) else $error("tx flag moved");
    rxready_drop_a: assert property ($fell(rx_ready_flag) |->
        $past(psel, 1) || $past(psel, 2) || $past(psel, 3)) else $error("rx ready fell");
    error_suppress_a: assert property (summary_error_event |-> !rx_ready_flag)
        else $error("ready not suppressed");
    // main scenarios reached
    cover property (rx_ready_flag);
    cover property (summary_error_event);
    cover property (pslverr);
endmodule : uar_chk
bind uar_receiver uar_chk chk_i (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .rx_ready_flag(rx_ready_flag),
    .summary_error_event(summary_error_event), .tx_buffer_free_flag(tx_buffer_free_flag));
`default_nettype wire

// ==== bench/uar_txm.sv ====
`timescale 1ns/1ps
`default_nettype none
module uar_txm (
    input wire logic core_clk,
    output var logic line
);
    initial line = 1'b1;
    // one bit cell, level held bc clocks
    task automatic put(input logic b, input int bc, input logic inv);
        line <= b ^ inv;
        repeat (bc) @(posedge core_clk);
    endtask : put
    // start, data lsb first, optional ninth bit, stop, one idle cell
    task automatic send(input logic [7:0] d, input int nd, input int par, input logic stop,
                        input int bc, input logic inv);
        @(posedge core_clk);
        put(1'b0, bc, inv);
        for (int i = 0; i < nd; i++) put(d[i], bc, inv);
        if (par < 2) put(par[0], bc, inv);
        put(stop, bc, inv);
        put(1'b1, bc, inv);
    endtask : send
    // short low pulse, too short for a start bit
    task automatic pulse(input int n);
        @(posedge core_clk);
        put(1'b0, n, 1'b0);
        put(1'b1, 40, 1'b0);
    endtask : pulse
endmodule : uar_txm
`default_nettype wire

// ==== bench/uar_receiver_tb.sv ====
`timescale 1ns/1ps
`include "uar_params.svh"
`default_nettype none
module uar_receiver_tb;
    logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, e;
    logic        rx_ready_flag, summary_error_event, tx_buffer_free_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    wire logic   rx_pin;
    int          num_errors, check_count;
    uar_receiver dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pin(rx_pin), .rx_ready_flag(rx_ready_flag),
        .summary_error_event(summary_error_event), .tx_buffer_free_flag(tx_buffer_free_flag));
    uar_txm model (.core_clk(core_clk), .line(rx_pin));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task close_out;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin num_errors++; close_out(); end
        rd = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, x);
    endtask : rdc
    // reset values, unmapped place, transmitter start-up
    task s_setup;
        rdc("ctrl", `UAR_OFF_CTRL, 32'h0);
        rdc("baud", `UAR_OFF_BAUD, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", {31'h0, e}, 32'h1);
        apb(1'b1, `UAR_OFF_BAUD, 32'h0);
        apb(1'b1, `UAR_OFF_CTRL, 32'h3);
        rdc("st_notx", `UAR_OFF_STATUS, 32'h00);
        apb(1'b1, `UAR_OFF_CTRL, 32'h7);
        rdc("st_tx", `UAR_OFF_STATUS, 32'h08);
    endtask : s_setup
    // every mode, good and bad parity with its enable set
    task s_modes;
        logic [31:0] x;
        for (int m = 0; m < 4; m++) for (int b = 0; b < 2; b++) if (m >= 2 || b == 0) begin
            apb(1'b1, `UAR_OFF_CTRL, 32'h47 | (m << 8));
            model.send(8'hc6, m == 1 ? 7 : 8, m < 2 ? 2 : ((m == 2) ^ b), 1'b1, 16, 1'b0);
            x = 32'h48 | (b ? 32'h14 : 32'h01);
            rdc("st_mode", `UAR_OFF_STATUS, x);
            chk("ready", {31'h0, rx_ready_flag}, {31'h0, !b});
            chk("sumev", {31'h0, summary_error_event}, {31'h0, b});
            rdc("rxbuf", `UAR_OFF_RXBUF, m == 1 ? 32'h46 : 32'hc6);
            rdc("st_empty", `UAR_OFF_STATUS, 32'h08);
        end
    endtask : s_modes
    // break then clean byte; port off empties fifo
    task s_ferr;
        apb(1'b1, `UAR_OFF_CTRL, 32'h27);
        model.send(8'h00, 8, 2, 1'b0, 16, 1'b0);
        model.send(8'h3c, 8, 2, 1'b1, 16, 1'b0);
        rdc("st_ferr", `UAR_OFF_STATUS, 32'h9a);
        rdc("rx_break", `UAR_OFF_RXBUF, 32'h00);
        rdc("st_next", `UAR_OFF_STATUS, 32'h49);
        apb(1'b1, `UAR_OFF_CTRL, 32'h26);
        rdc("st_off", `UAR_OFF_STATUS, 32'h00);
    endtask : s_ferr
    // three bytes unread: two kept, third dropped
    task s_fifo;
        apb(1'b1, `UAR_OFF_CTRL, 32'h07);
        model.send(8'h11, 8, 2, 1'b1, 16, 1'b0);
        model.send(8'h22, 8, 2, 1'b1, 16, 1'b0);
        model.send(8'h33, 8, 2, 1'b1, 16, 1'b0);
        rdc("st_full", `UAR_OFF_STATUS, 32'ha9);
        rdc("rx_1", `UAR_OFF_RXBUF, 32'h11);
        rdc("rx_2", `UAR_OFF_RXBUF, 32'h22);
        apb(1'b1, `UAR_OFF_STATUS, 32'h20);
        rdc("st_clr", `UAR_OFF_STATUS, 32'h08);
    endtask : s_fifo
    // glitch and short start rejected silently, then a real byte
    task s_glitch;
        model.pulse(1);
        model.pulse(5);
        rdc("st_glitch", `UAR_OFF_STATUS, 32'h08);
        model.send(8'h81, 8, 2, 1'b1, 16, 1'b0);
        rdc("rx_after", `UAR_OFF_RXBUF, 32'h81);
    endtask : s_glitch
    // high speed with inverted line
    task s_fast_inv;
        apb(1'b1, `UAR_OFF_CTRL, 32'h18);
        model.put(1'b1, 2, 1'b1);
        apb(1'b1, `UAR_OFF_CTRL, 32'h1f);
        model.send(8'h5a, 8, 2, 1'b1, 4, 1'b1);
        rdc("st_fast", `UAR_OFF_STATUS, 32'h49);
        rdc("rx_fast", `UAR_OFF_RXBUF, 32'h5a);
    endtask : s_fast_inv
    initial begin
        num_errors = 0; check_count = 0;
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0;
        repeat (4) @(posedge core_clk);
        chk("outs", {29'h0, rx_ready_flag, summary_error_event, tx_buffer_free_flag}, 32'h0);
        rstn <= 1'b1;
        s_setup();
        s_modes();
        s_ferr();
        s_fifo();
        s_glitch();
        s_fast_inv();
        close_out();
    end
endmodule : uar_receiver_tb
`default_nettype wire
